// *** ilfb_chk_asserts.sv ***
// port checker for the interrupt level and flag bank
// assumes one clock domain and the register map starting at 0x70
`timescale 1ns/1ps
`default_nettype none
module ilfb_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [21:0] src_event,
    input wire logic external_input_zero,
    input wire logic ext_zero_level_mode,
    input wire logic [21:0] request_pending_flag,
    input wire logic [65:0] request_priority_field,
    input wire logic [21:0] req_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    lvl_gate_a: assert property (req_active[2] == (request_pending_flag[2] &&
        request_priority_field[8:6] != 3'h0 && request_priority_field[8:6] != 3'h7))
        else $error("request active does not match flag and level");
    lvl_write_a: assert property (reg_wr && reg_addr == 8'h71 |=>
        request_priority_field[8:6] == $past(reg_wdata[2:0])) else $error("level not loaded");
    flag_read_a: assert property (reg_rd && reg_addr == 8'h71 |=> reg_rdata ==
        {$past(request_pending_flag[3]), 3'h0, $past(request_pending_flag[2]), 3'h0})
        else $error("read data does not show flags");
    wr_clear_a: assert property (reg_wr && reg_addr == 8'h71 && !reg_wdata[3] &&
        !src_event[2] |=> !request_pending_flag[2]) else $error("flag not cleared");
    ext_level_a: assert property ((ext_zero_level_mode && external_input_zero)[*7]
        |-> request_pending_flag[0]) else $error("level mode flag not following pin");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    cover property (reg_rd && reg_addr == 8'h7B);
    cover property (|req_active);
    cover property (reg_wr && reg_addr == 8'h70 && ext_zero_level_mode);
endmodule
bind ilfb_irq_bank ilfb_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .external_input_zero(external_input_zero),
    .ext_zero_level_mode(ext_zero_level_mode),
    .request_pending_flag(request_pending_flag),
    .request_priority_field(request_priority_field), .req_active(req_active));
`default_nettype wire

// *** ilfb_cpu_model.sv ***
// cpu acceptance model: acknowledges the lowest active source
// assumes req_active from the bank; ack_dly sets how slowly it answers
`timescale 1ns/1ps
`default_nettype none
module ilfb_cpu_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [21:0] req_active,
    input wire logic [3:0] ack_dly,
    output logic [21:0] ack_clear
);
    logic [3:0] cnt;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            ack_clear <= 22'h0;
        end else begin
            ack_clear <= 22'h0;
            // restart after each ack so one request is taken per wait
            if (req_active == 22'h0 || ack_clear != 22'h0)
                cnt <= 4'h0;
            else if (cnt < ack_dly)
                cnt <= cnt + 4'h1;
            else
                ack_clear <= req_active & (~req_active + 22'h1);
        end
    end
endmodule
`default_nettype wire

// *** ilfb_defs.vh ***
// constants for the interrupt level and flag bank
// included by ilfb_irq_bank.v; definitions only
`ifndef ILFB_DEFS_VH
`define ILFB_DEFS_VH

`define ILFB_ADDR_W 8
`define ILFB_DATA_W 8
`define ILFB_REG_COUNT 11
`define ILFB_SRC_COUNT 22
`define ILFB_LVL_W 3

`define ILFB_ADC_EXT0_OFFSET 8'h70
`define ILFB_EXT1_EXT2_OFFSET 8'h71
`define ILFB_EXT3_EXT4_OFFSET 8'h72
`define ILFB_EXT5_EXT6_OFFSET 8'h73
`define ILFB_EXT7_EXT8_OFFSET 8'h74
`define ILFB_TMR0_TMR1_OFFSET 8'h75
`define ILFB_TMR2_TMR3_OFFSET 8'h76
`define ILFB_TMR4_TMR5_OFFSET 8'h77
`define ILFB_TMR6_TMR7_OFFSET 8'h78
`define ILFB_TMR8_PAIR_OFFSET 8'h79
`define ILFB_TMR9_PAIR_OFFSET 8'h7A
`define ILFB_FIRST_OFFSET `ILFB_ADC_EXT0_OFFSET
`define ILFB_LAST_OFFSET `ILFB_TMR9_PAIR_OFFSET

`define ILFB_REG_RESET 8'h00
`define ILFB_NIBBLE_W 4
`define ILFB_FLAG_BIT 3
`define ILFB_LVL_LSB 0

`define ILFB_LVL_OFF_LOW 3'h0
`define ILFB_LVL_OFF_HIGH 3'h7

`define ILFB_EXT_ZERO_SRC 0

`endif

// *** ilfb_irq_bank.v ***
// interrupt level and pending flag bank, two sources per byte register
// assumes a single-cycle register port and same-clock event pulses;
// external input zero arrives asynchronously from a pin
//
// Added by the designer: the address-and-strobe port.
`include "ilfb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ilfb_irq_bank (
    input wire clk_sys,
    input wire rst_n,
    input wire [`ILFB_ADDR_W-1:0] reg_addr,
    input wire [`ILFB_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`ILFB_DATA_W-1:0] reg_rdata,
    input wire [`ILFB_SRC_COUNT-1:0] src_event,
    input wire [`ILFB_SRC_COUNT-1:0] ack_clear,
    input wire external_input_zero,
    input wire ext_zero_level_mode,
    output reg [`ILFB_SRC_COUNT-1:0] request_pending_flag,
    output reg [`ILFB_SRC_COUNT*`ILFB_LVL_W-1:0] request_priority_field,
    output wire [`ILFB_SRC_COUNT-1:0] req_active
);

    localparam [3:0] IDX_NONE = 4'hF;

    // one decode serves both the write and the read path
    function [3:0] reg_index;
        input [`ILFB_ADDR_W-1:0] a;
        begin
            case (a)
                `ILFB_ADC_EXT0_OFFSET: reg_index = 4'h0;
                `ILFB_EXT1_EXT2_OFFSET: reg_index = 4'h1;
                `ILFB_EXT3_EXT4_OFFSET: reg_index = 4'h2;
                `ILFB_EXT5_EXT6_OFFSET: reg_index = 4'h3;
                `ILFB_EXT7_EXT8_OFFSET: reg_index = 4'h4;
                `ILFB_TMR0_TMR1_OFFSET: reg_index = 4'h5;
                `ILFB_TMR2_TMR3_OFFSET: reg_index = 4'h6;
                `ILFB_TMR4_TMR5_OFFSET: reg_index = 4'h7;
                `ILFB_TMR6_TMR7_OFFSET: reg_index = 4'h8;
                `ILFB_TMR8_PAIR_OFFSET: reg_index = 4'h9;
                `ILFB_TMR9_PAIR_OFFSET: reg_index = 4'hA;
                default: reg_index = IDX_NONE;
            endcase
        end
    endfunction

    function addr_hit;
        input [`ILFB_ADDR_W-1:0] a;
        begin
            addr_hit = (reg_index(a) != IDX_NONE);
        end
    endfunction

    function level_enabled;
        input [`ILFB_LVL_W-1:0] lvl;
        begin
            level_enabled = (lvl != `ILFB_LVL_OFF_LOW) &&
                            (lvl != `ILFB_LVL_OFF_HIGH);
        end
    endfunction

    // level bits never read back, so a byte shows only the two flags
    function [`ILFB_DATA_W-1:0] pack_flags;
        input [1:0] f;
        begin
            pack_flags = {f[1], 3'h0, f[0], 3'h0};
        end
    endfunction

    wire wr_hit;
    wire rd_hit;
    wire [3:0] wr_index;
    wire [3:0] rd_index;
    assign wr_hit = reg_wr && addr_hit(reg_addr);
    assign rd_hit = reg_rd && addr_hit(reg_addr);
    assign wr_index = reg_index(reg_addr);
    assign rd_index = reg_index(reg_addr);

    // one select line per register keeps the source loop free of compares
    wire [`ILFB_REG_COUNT-1:0] wr_sel;
    genvar r;
    generate
        for (r = 0; r < `ILFB_REG_COUNT; r = r + 1) begin : g_reg
            assign wr_sel[r] = wr_hit && (wr_index == r);
        end
    endgenerate

    // pin synchroniser: a change counts once stages two and three agree
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg ext_level;
    reg next_ext_level;
    wire ext_agree;
    wire ext_rise;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1 <= 1'h0;
        end else begin
            ext_s1 <= external_input_zero;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_s2 <= 1'h0;
        end else begin
            ext_s2 <= ext_s1;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_s3 <= 1'h0;
        end else begin
            ext_s3 <= ext_s2;
        end
    end

    assign ext_agree = (ext_s2 == ext_s3);

    always @* begin
        next_ext_level = ext_level;
        if (ext_agree) begin
            next_ext_level = ext_s2;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_level <= 1'h0;
        end else begin
            ext_level <= next_ext_level;
        end
    end

    // edge taken against the filtered level, so a one-cycle glitch never sets
    assign ext_rise = ext_agree && ext_s2 && !ext_level;

    genvar i;
    generate
        for (i = 0; i < `ILFB_SRC_COUNT; i = i + 1) begin : g_src
            localparam integer NIB = (i % 2) * `ILFB_NIBBLE_W;
            wire sel;
            wire wr_clear;
            wire set_evt;
            wire clr_evt;
            wire hold_level;
            wire [`ILFB_LVL_W-1:0] lvl_now;
            reg next_flag;
            reg [`ILFB_LVL_W-1:0] next_lvl;

            assign sel = wr_sel[i / 2];
            // whole-byte write of a zero flag bit clears, a one is ignored
            assign wr_clear = sel && !reg_wdata[NIB + `ILFB_FLAG_BIT];
            assign lvl_now = request_priority_field[i*`ILFB_LVL_W +: `ILFB_LVL_W];

            if (i == `ILFB_EXT_ZERO_SRC) begin : g_ext
                assign set_evt = ext_rise;
                assign hold_level = ext_zero_level_mode;
            end else begin : g_std
                assign set_evt = src_event[i];
                assign hold_level = 1'h0;
            end
            assign clr_evt = wr_clear || ack_clear[i];

            always @* begin
                next_flag = request_pending_flag[i];
                if (hold_level) begin
                    // software and core clears have no effect in level mode
                    next_flag = ext_level;
                end else if (set_evt) begin
                    // set wins so a same-cycle event is never lost
                    next_flag = 1'h1;
                end else if (clr_evt) begin
                    next_flag = 1'h0;
                end
            end

            // every write loads both levels; a partial update is impossible
            always @* begin
                next_lvl = lvl_now;
                if (sel) begin
                    next_lvl = reg_wdata[NIB + `ILFB_LVL_LSB +: `ILFB_LVL_W];
                end
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    request_pending_flag[i] <= 1'h0;
                end else begin
                    request_pending_flag[i] <= next_flag;
                end
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    request_priority_field[i*`ILFB_LVL_W +: `ILFB_LVL_W] <=
                        `ILFB_LVL_OFF_LOW;
                end else begin
                    request_priority_field[i*`ILFB_LVL_W +: `ILFB_LVL_W] <=
                        next_lvl;
                end
            end

            // codes 0 and 7 both keep the source away from the core
            assign req_active[i] = request_pending_flag[i] &&
                level_enabled(lvl_now);
        end
    endgenerate

    // level fields are write-only and read as zero
    reg [`ILFB_DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = `ILFB_REG_RESET;
        if (rd_hit) begin
            case (rd_index)
                4'h0: begin
                    next_rdata = pack_flags(request_pending_flag[1:0]);
                end

                4'h1: begin
                    next_rdata = pack_flags(request_pending_flag[3:2]);
                end

                4'h2: begin
                    next_rdata = pack_flags(request_pending_flag[5:4]);
                end

                4'h3: begin
                    next_rdata = pack_flags(request_pending_flag[7:6]);
                end

                4'h4: begin
                    next_rdata = pack_flags(request_pending_flag[9:8]);
                end

                4'h5: begin
                    next_rdata = pack_flags(request_pending_flag[11:10]);
                end

                4'h6: begin
                    next_rdata = pack_flags(request_pending_flag[13:12]);
                end

                4'h7: begin
                    next_rdata = pack_flags(request_pending_flag[15:14]);
                end

                4'h8: begin
                    next_rdata = pack_flags(request_pending_flag[17:16]);
                end

                4'h9: begin
                    next_rdata = pack_flags(request_pending_flag[19:18]);
                end

                4'hA: begin
                    next_rdata = pack_flags(request_pending_flag[21:20]);
                end

                default: begin
                    next_rdata = `ILFB_REG_RESET;
                end
            endcase
        end
    end

    // read data stand one cycle only, then fall back to zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `ILFB_REG_RESET;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// *** ilfb_irq_bank_tb.sv ***
// self-checking bench for the interrupt level and flag bank
// assumes the cpu model on the acknowledge side
`timescale 1ns/1ps
`default_nettype none
module ilfb_irq_bank_tb;
    logic clk_sys = 0, rst_n = 0, wr = 0, rd = 0, pin = 0, lm = 0;
    logic [7:0] a = 8'h00, wd = 8'h00, rdat;
    logic [21:0] ev = 22'h0, ack, pf, act;
    logic [65:0] pr;
    logic [3:0] dly = 4'hF;
    int error_cnt = 0, comparisons = 0;
    always #20 clk_sys = ~clk_sys;
    ilfb_irq_bank u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(a),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .src_event(ev), .ack_clear(ack), .external_input_zero(pin),
        .ext_zero_level_mode(lm), .request_pending_flag(pf),
        .request_priority_field(pr), .req_active(act));
    ilfb_cpu_model u_cpu (.clk_sys(clk_sys), .rst_n(rst_n),
        .req_active(act), .ack_dly(dly), .ack_clear(ack));
    task chk(input logic [31:0] s, input logic [31:0] e, input string n);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // whole bytes only: levels do not read back
    task wrr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys); a <= ad; wd <= d; wr <= 1;
        @(posedge clk_sys); wr <= 0;
    endtask
    task rdc(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk_sys); a <= ad; rd <= 1;
        @(posedge clk_sys); rd <= 0;
        #1 chk(rdat, e, "rdata");
    endtask
    task ev1(input int i);
        @(posedge clk_sys); ev <= 22'h1 << i;
        @(posedge clk_sys); ev <= 22'h0;
        #1;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1;
        for (int k = 0; k < 12; k++) rdc(8'h70 + k, 8'h00);
        for (int l = 0; l < 8; l++) begin
            wrr(8'h71, {1'b1, l[2:0], 1'b1, l[2:0]});
            ev1(2);
            chk(act[2], l != 0 && l != 7, "active");
            chk(pr[11:9], l[2:0], "level");
            wrr(8'h71, 8'h00);
        end
        $display("levels done");
        ev1(3);
        rdc(8'h71, 8'h80);
        wrr(8'h71, 8'h88);
        rdc(8'h71, 8'h80);
        wrr(8'h71, 8'h08);
        rdc(8'h71, 8'h00);
        dly <= 4'h2;
        wrr(8'h75, 8'h04);
        wrr(8'h7B, 8'hFF);
        ev1(10);
        repeat (6) @(posedge clk_sys);
        #1 chk(pf, 0, "acked");
        chk(pr[32:30], 3'h4, "unmapped");
        $display("flags done");
        lm <= 1; pin <= 1;
        repeat (8) @(posedge clk_sys);
        wrr(8'h70, 8'h00);
        #1 chk(pf[0], 1, "level pin");
        pin <= 0;
        repeat (8) @(posedge clk_sys);
        #1 chk(pf[0], 0, "level pin");
        lm <= 0; pin <= 1;
        repeat (8) @(posedge clk_sys);
        pin <= 0;
        repeat (8) @(posedge clk_sys);
        #1 chk(pf[0], 1, "edge pin");
        wrr(8'h70, 8'h00);
        #1 chk(pf[0], 0, "edge clear");
        $display("pin done");
        close_out();
    end
endmodule
`default_nettype wire
